//--- src/cor_pkg.sv
package cor_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_OUT = 10;
    localparam int CODE_W = 4;
    localparam int RATIO_W = 5;
    localparam int CTRL_W = 3;
    localparam int REF_W = 3;
    localparam int SYNC_STAGES = 3;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_DIV = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_REF_CFG = 5'h15;
    localparam logic [ADDR_W-1:0] ADDR_RELOCK = 5'h16;
    localparam logic [ADDR_W-1:0] ADDR_CFG_SRC = 5'h1b;
    localparam logic [ADDR_W-1:0] OUT_CTRL_ADDR [NUM_OUT] = '{
        5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h10, 5'h11, 5'h17, 5'h18, 5'h19
    };

    // Field positions
    localparam int PD_BIT = 2;
    localparam int OE_BIT = 1;
    localparam int FMT_BIT = 0;
    localparam int RANGE_BIT = 2;
    localparam int VREG_BIT = 1;
    localparam int REFSRC_BIT = 0;
    localparam int RELOCK_BIT = 0;
    localparam int CFGSRC_BIT = 0;

    // Reset values
    localparam logic [CODE_W-1:0] DIV_CODE_RST = 4'h9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h2;
    localparam logic [REF_W-1:0] REF_CFG_RST = 3'h0;
    localparam logic CFG_SRC_RST = 1'b0;

    // Divide ratio per code, zero marks a reserved code
    localparam logic [CODE_W-1:0] CODE_RSVD_MIN = 4'hc;
    localparam logic [RATIO_W-1:0] DIV_RATIO_TABLE [16] = '{
        5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0a,
        5'h0c, 5'h10, 5'h14, 5'h18, 5'h00, 5'h00, 5'h00, 5'h00
    };
    localparam logic [RATIO_W-1:0] RATIO_RST = DIV_RATIO_TABLE[DIV_CODE_RST];

    typedef logic [CTRL_W-1:0] cor_ctrl_type;

endpackage

//--- src/cor_div_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cor_div_if;
    import cor_pkg::*;
    logic [CODE_W-1:0] code;
    logic [RATIO_W-1:0] ratio;
    logic rsvd;
    modport dec (input code, output ratio, output rsvd);
    modport user (output code, input ratio, input rsvd);
endinterface

`default_nettype wire

//--- src/cor_div_decode.sv
`timescale 1ns/1ps
`default_nettype none

module cor_div_decode (
    // Code in, ratio out
    cor_div_if.dec bus
);
    import cor_pkg::*;

    logic code_rsvd;

    assign code_rsvd = bus.code >= CODE_RSVD_MIN;
    assign bus.rsvd = code_rsvd;
    assign bus.ratio = code_rsvd ? '0 : DIV_RATIO_TABLE[bus.code];
endmodule

`default_nettype wire

//--- src/cor_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cor_sync #(
    parameter int W = 1
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Pin side and synchronous side
    input wire logic [W-1:0] d_i,
    output var logic [W-1:0] q_o
);
    import cor_pkg::*;

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic agree;

    if (W < 1) begin : g_chk
        $error("cor_sync needs W of at least one");
    end

    assign agree = s2_r == s3_r;

    // Change accepted only once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                q_o <= s3_r;
            end
        end
    end
endmodule

`default_nettype wire

//--- src/cor_clock_output_regs.sv
`timescale 1ns/1ps
`default_nettype none

module cor_clock_output_regs #(
    parameter int N_OUT = cor_pkg::NUM_OUT
) (
    // Clock, reset and enable
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Register port
    input wire logic [cor_pkg::ADDR_W-1:0] REG_ADDR_I,
    input wire logic [cor_pkg::DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output var logic [cor_pkg::DATA_W-1:0] REG_RDATA_O,
    output var logic REG_RVALID_O,
    // Strap pins
    input wire logic [cor_pkg::CODE_W-1:0] STRAP_DIV_CODE_I,
    input wire logic STRAP_REF_SOURCE_I,
    // Per output buffer controls
    output var logic [N_OUT-1:0] BUFFER_POWERDOWN_O,
    output var logic [N_OUT-1:0] BUFFER_OUTPUT_ENABLE_O,
    output var logic [N_OUT-1:0] OUTPUT_FORMAT_SELECT_O,
    // Shared divider
    output var logic [cor_pkg::RATIO_W-1:0] DIV_RATIO_O,
    output var logic DIV_CODE_RSVD_O,
    // Reference and PLL controls
    output var logic PLL_LOCK_RESTART_O,
    output var logic CRYSTAL_RANGE_SELECT_O,
    output var logic OSC_REGULATOR_LEVEL_O,
    output var logic REF_SOURCE_O,
    output var logic CONFIG_SOURCE_BIT_O
);
    import cor_pkg::*;

    if (N_OUT < 1 || N_OUT > NUM_OUT) begin : g_chk
        $error("N_OUT must lie between one and the number of control registers");
    end

    logic wr_en;
    logic wr_div;
    logic wr_ref;
    logic wr_relock;
    logic wr_cfgsrc;
    logic hit_div;
    logic hit_ref;
    logic hit_relock;
    logic hit_cfgsrc;
    logic [CODE_W-1:0] div_code_r;
    logic [REF_W-1:0] ref_cfg_r;
    logic cfg_src_r;
    logic relock_r;
    logic [RATIO_W-1:0] ratio_r;
    logic rsvd_r;
    logic ref_src_r;
    logic [DATA_W-1:0] rd_data_r;
    logic rvalid_r;
    logic [CODE_W:0] strap_q;
    logic [CODE_W-1:0] eff_code;
    logic eff_ref_src;
    logic [RATIO_W-1:0] ratio_nxt;
    logic [N_OUT-1:0] ctrl_hit;
    logic [CTRL_W-1:0] ctrl_or [N_OUT+1];
    logic [DATA_W-1:0] rd_mux;

    cor_div_if div_bus ();

    // Address decode
    assign wr_en = CE_I && REG_WR_I;
    assign hit_div = REG_ADDR_I == ADDR_DIV;
    assign hit_ref = REG_ADDR_I == ADDR_REF_CFG;
    assign hit_relock = REG_ADDR_I == ADDR_RELOCK;
    assign hit_cfgsrc = REG_ADDR_I == ADDR_CFG_SRC;
    assign wr_div = wr_en && hit_div;
    assign wr_ref = wr_en && hit_ref;
    assign wr_relock = wr_en && hit_relock && REG_WDATA_I[RELOCK_BIT];
    assign wr_cfgsrc = wr_en && hit_cfgsrc;

    // Per output control registers
    assign ctrl_or[0] = '0;
    for (genvar i = 0; i < N_OUT; i++) begin : g_out
        cor_ctrl_type ctrl_r;

        assign ctrl_hit[i] = REG_ADDR_I == OUT_CTRL_ADDR[i];
        assign ctrl_or[i+1] = ctrl_or[i] | (ctrl_hit[i] ? ctrl_r : '0);

        always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                ctrl_r <= CTRL_RST;
            end else if (wr_en && ctrl_hit[i]) begin
                ctrl_r <= REG_WDATA_I[CTRL_W-1:0];
            end
        end

        assign BUFFER_POWERDOWN_O[i] = ctrl_r[PD_BIT];
        assign BUFFER_OUTPUT_ENABLE_O[i] = ctrl_r[OE_BIT];
        assign OUTPUT_FORMAT_SELECT_O[i] = ctrl_r[FMT_BIT];
    end

    // Strap pins cross in from outside the clock domain
    cor_sync #(
        .W(CODE_W + 1)
    ) u_strap_sync (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .d_i({STRAP_REF_SOURCE_I, STRAP_DIV_CODE_I}),
        .q_o(strap_q)
    );

    // Pins or registers govern divider and reference choice
    assign eff_code = cfg_src_r ? div_code_r : strap_q[CODE_W-1:0];
    assign eff_ref_src = cfg_src_r ? ref_cfg_r[REFSRC_BIT] : strap_q[CODE_W];

    assign div_bus.code = eff_code;

    cor_div_decode u_div_decode (
        .bus(div_bus.dec)
    );

    // Reserved code keeps the last legal ratio
    assign ratio_nxt = div_bus.rsvd ? ratio_r : div_bus.ratio;

    // Readback, reserved bits as zero
    assign rd_mux = hit_div ? DATA_W'(div_code_r) :
                    hit_ref ? DATA_W'(ref_cfg_r) :
                    hit_relock ? DATA_W'(relock_r) :
                    hit_cfgsrc ? DATA_W'(cfg_src_r) :
                    DATA_W'(ctrl_or[N_OUT]);

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_code_r <= DIV_CODE_RST;
        end else if (wr_div) begin
            div_code_r <= REG_WDATA_I[CODE_W-1:0];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ref_cfg_r <= REF_CFG_RST;
        end else if (wr_ref) begin
            ref_cfg_r <= REG_WDATA_I[REF_W-1:0];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cfg_src_r <= CFG_SRC_RST;
        end else if (wr_cfgsrc) begin
            cfg_src_r <= REG_WDATA_I[CFGSRC_BIT];
        end
    end

    // Self-clearing relock, a new write wins over the clear
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            relock_r <= 1'b0;
        end else if (CE_I) begin
            relock_r <= wr_relock;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ratio_r <= RATIO_RST;
            rsvd_r <= 1'b0;
            ref_src_r <= 1'b0;
        end else if (CE_I) begin
            ratio_r <= ratio_nxt;
            rsvd_r <= div_bus.rsvd;
            ref_src_r <= eff_ref_src;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_data_r <= '0;
            rvalid_r <= 1'b0;
        end else if (CE_I) begin
            rvalid_r <= REG_RD_I;
            if (REG_RD_I) begin
                rd_data_r <= rd_mux;
            end
        end
    end

    assign REG_RDATA_O = rd_data_r;
    assign REG_RVALID_O = rvalid_r;
    assign DIV_RATIO_O = ratio_r;
    assign DIV_CODE_RSVD_O = rsvd_r;
    assign PLL_LOCK_RESTART_O = relock_r;
    assign CRYSTAL_RANGE_SELECT_O = ref_cfg_r[RANGE_BIT];
    assign OSC_REGULATOR_LEVEL_O = ref_cfg_r[VREG_BIT];
    assign REF_SOURCE_O = ref_src_r;
    assign CONFIG_SOURCE_BIT_O = cfg_src_r;

    // Checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_div_small_codes: assert property (
        (CE_I && eff_code <= 4'h5) |=> DIV_RATIO_O == RATIO_W'($past(eff_code)) + 5'h01
    ) else $error("Divide codes up to five must give code plus one");

    a_div_top_code: assert property (
        (CE_I && eff_code == 4'hb) |=> DIV_RATIO_O == 5'h18
    ) else $error("Divide code eleven must give divide by twenty-four");

    a_div_rsvd_hold: assert property (
        (CE_I && eff_code >= 4'hc) |=> DIV_CODE_RSVD_O && $stable(DIV_RATIO_O)
    ) else $error("Reserved divide code must flag and hold the ratio");

    a_div_code_store: assert property (
        (wr_div && !wr_cfgsrc && cfg_src_r) ##1 (CE_I && !wr_div)
            |=> DIV_RATIO_O == DIV_RATIO_TABLE[$past(REG_WDATA_I[CODE_W-1:0], 2)]
            || DIV_CODE_RSVD_O
    ) else $error("Written divide code must reach the ratio in two cycles");

    a_rsvd_read_zero: assert property (
        REG_RVALID_O |-> REG_RDATA_O[DATA_W-1:CODE_W] == '0
    ) else $error("Reserved read bits must be zero");

    a_out_ctrl_write: assert property (
        (wr_en && REG_ADDR_I == 5'h10)
            |=> BUFFER_POWERDOWN_O[5] == $past(REG_WDATA_I[PD_BIT])
            && BUFFER_OUTPUT_ENABLE_O[5] == $past(REG_WDATA_I[OE_BIT])
            && OUTPUT_FORMAT_SELECT_O[5] == $past(REG_WDATA_I[FMT_BIT])
    ) else $error("Control register sixteen must drive output five");

    a_relock_set: assert property (
        wr_relock |=> PLL_LOCK_RESTART_O
    ) else $error("Relock write must raise the pulse");

    a_relock_clear: assert property (
        (PLL_LOCK_RESTART_O && CE_I && !wr_relock) |=> !PLL_LOCK_RESTART_O
    ) else $error("Relock pulse must clear after one cycle");

    a_ref_cfg_write: assert property (
        wr_ref |=> CRYSTAL_RANGE_SELECT_O == $past(REG_WDATA_I[RANGE_BIT])
            && OSC_REGULATOR_LEVEL_O == $past(REG_WDATA_I[VREG_BIT])
    ) else $error("Reference configuration write must reach its outputs");

    a_ref_from_reg: assert property (
        (wr_ref && cfg_src_r && !wr_cfgsrc) ##1 CE_I
            |=> REF_SOURCE_O == $past(REG_WDATA_I[REFSRC_BIT], 2)
    ) else $error("Reference source must follow the register");

    a_ref_from_pin: assert property (
        (CE_I && !cfg_src_r) |=> REF_SOURCE_O == $past(strap_q[CODE_W])
    ) else $error("Reference source must follow the strap when pins govern");

    a_div_rsvd_clear: assert property (
        (CE_I && eff_code < CODE_RSVD_MIN) |=> !DIV_CODE_RSVD_O
    ) else $error("Legal divide code must clear the reserved flag");

    a_rd_div_data: assert property (
        (CE_I && REG_RD_I && hit_div) |=> REG_RVALID_O && REG_RDATA_O == DATA_W'($past(div_code_r))
    ) else $error("Divide register read must return the stored code");

    a_relock_zero_write: assert property (
        (wr_en && hit_relock && !REG_WDATA_I[RELOCK_BIT]) |=> !PLL_LOCK_RESTART_O
    ) else $error("Writing zero to the relock register must not pulse");

    a_cfg_src_write: assert property (
        wr_cfgsrc |=> CONFIG_SOURCE_BIT_O == $past(REG_WDATA_I[CFGSRC_BIT])
    ) else $error("Configuration source write must reach its output");

    a_out_ctrl_first: assert property (
        (wr_en && REG_ADDR_I == 5'h01)
            |=> BUFFER_POWERDOWN_O[0] == $past(REG_WDATA_I[PD_BIT])
            && BUFFER_OUTPUT_ENABLE_O[0] == $past(REG_WDATA_I[OE_BIT])
            && OUTPUT_FORMAT_SELECT_O[0] == $past(REG_WDATA_I[FMT_BIT])
    ) else $error("Control register one must drive output zero");

    a_out_ctrl_last: assert property (
        (wr_en && REG_ADDR_I == 5'h19)
            |=> BUFFER_POWERDOWN_O[9] == $past(REG_WDATA_I[PD_BIT])
            && BUFFER_OUTPUT_ENABLE_O[9] == $past(REG_WDATA_I[OE_BIT])
            && OUTPUT_FORMAT_SELECT_O[9] == $past(REG_WDATA_I[FMT_BIT])
    ) else $error("Control register twenty-five must drive output nine");

    a_rd_valid_pulse: assert property (
        (CE_I && !REG_RD_I) |=> !REG_RVALID_O
    ) else $error("Read valid must only follow a read strobe");

    c_relock: cover property (wr_relock ##1 PLL_LOCK_RESTART_O ##1 !PLL_LOCK_RESTART_O);
    c_rsvd_code: cover property (CE_I && div_bus.rsvd ##1 DIV_CODE_RSVD_O);
    c_pin_to_reg: cover property (!CONFIG_SOURCE_BIT_O ##1 CONFIG_SOURCE_BIT_O);
    c_powerdown: cover property (wr_en && ctrl_hit[0] && REG_WDATA_I[PD_BIT] ##1 BUFFER_POWERDOWN_O[0]);
    c_strap_ref: cover property (!cfg_src_r && CE_I && strap_q[CODE_W] ##1 REF_SOURCE_O);

endmodule

`default_nettype wire

//--- tb/cor_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cor_host_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [cor_pkg::ADDR_W-1:0] addr_o,
    output logic [cor_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [cor_pkg::DATA_W-1:0] rdata_i,
    input wire logic rvalid_i
);
    import cor_pkg::*;
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        v = rvalid_i;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

//--- tb/clock_output_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_output_config_regs_tb;
    import cor_pkg::*;
    localparam logic [4:0] CA [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h10, 5'h11, 5'h17, 5'h18, 5'h19};
    logic clk = 1'b0;
    logic rst_n, ce, sref, rv, rsvd, relock, xr, vl, refo, cfg;
    logic [3:0] scode, c;
    logic [4:0] addr, ratio, last, ex;
    logic [7:0] wd, rd_d;
    logic wr, rd;
    logic [9:0] pd, oe, fmt;
    logic [2:0] v [10];
    int seed = 21995;
    int mismatches = 0;
    int checked = 0;
    always #50 clk = ~clk;
    cor_clock_output_regs cor_clock_output_regs_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
        .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rd_d),
        .REG_RVALID_O(rv), .STRAP_DIV_CODE_I(scode), .STRAP_REF_SOURCE_I(sref),
        .BUFFER_POWERDOWN_O(pd), .BUFFER_OUTPUT_ENABLE_O(oe), .OUTPUT_FORMAT_SELECT_O(fmt),
        .DIV_RATIO_O(ratio), .DIV_CODE_RSVD_O(rsvd), .PLL_LOCK_RESTART_O(relock),
        .CRYSTAL_RANGE_SELECT_O(xr), .OSC_REGULATOR_LEVEL_O(vl), .REF_SOURCE_O(refo),
        .CONFIG_SOURCE_BIT_O(cfg));
    cor_host_model host (.clk_i(clk), .addr_o(addr), .wdata_o(wd), .wr_o(wr), .rd_o(rd),
        .rdata_i(rd_d), .rvalid_i(rv));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic vv;
        host.rd_reg(a, d, vv);
        chk("rvalid", 16'(vv), 16'h1);
        chk("rdata", 16'(d), 16'(exp));
    endtask
    function automatic logic [4:0] exp_ratio(input logic [3:0] k, input logic [4:0] prev);
        case (k)
            4'h6: return 5'h08;
            4'h7: return 5'h0a;
            4'h8: return 5'h0c;
            4'h9: return 5'h10;
            4'ha: return 5'h14;
            4'hb: return 5'h18;
            default: return (k < 4'h6) ? 5'(k) + 5'h01 : prev;
        endcase
    endfunction
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        scode = 4'h9;
        sref = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("oe", 16'(oe), 16'h3ff);
        chk("pd", 16'(pd), 16'h0);
        chk("fmt", 16'(fmt), 16'h0);
        chk("ratio", 16'(ratio), 16'h10);
        chk("xtal", 16'(xr), 16'h0);
        chk("vreg", 16'(vl), 16'h0);
        chk("ref", 16'(refo), 16'h0);
        chk("relock", 16'(relock), 16'h0);
        for (int i = 0; i < 10; i++) rdchk(CA[i], 8'h02);
        rdchk(5'h12, 8'h09);
        rdchk(5'h15, 8'h00);
        rdchk(5'h16, 8'h00);
        rdchk(5'h1b, 8'h00);
        rdchk(5'h1f, 8'h00);
        $display("test reset done");
        for (int n = 0; n < 3; n++) begin
            for (int i = 0; i < 10; i++) begin
                v[i] = 3'($random(seed));
                host.wr_reg(CA[i], {5'h00, v[i]});
            end
            for (int i = 0; i < 10; i++) begin
                chk("pd", 16'(pd[i]), 16'(v[i][2]));
                chk("oe", 16'(oe[i]), 16'(v[i][1]));
                chk("fmt", 16'(fmt[i]), 16'(v[i][0]));
                rdchk(CA[i], {5'h00, v[i]});
            end
        end
        host.wr_reg(CA[9], 8'hff);
        rdchk(CA[9], 8'h07);
        @(posedge clk);
        ce <= 1'b0;
        host.wr_reg(CA[0], {5'h00, ~v[0]});
        @(posedge clk);
        ce <= 1'b1;
        step();
        chk("ce", 16'(pd[0]), 16'(v[0][2]));
        $display("test output control done");
        host.wr_reg(5'h1b, 8'h01);
        chk("cfg", 16'(cfg), 16'h1);
        last = 5'h10;
        for (int k = 0; k < 17; k++) begin
            c = (k == 16) ? 4'h5 : 4'(k);
            host.wr_reg(5'h12, {4'h0, c});
            step();
            ex = exp_ratio(c, last);
            chk("ratio", 16'(ratio), 16'(ex));
            chk("rsvd", 16'(rsvd), 16'(c >= 4'hc));
            rdchk(5'h12, {4'h0, c});
            last = ex;
        end
        for (int k = 0; k < 8; k++) begin
            host.wr_reg(5'h15, 8'(k));
            step();
            chk("xtal", 16'(xr), 16'(k[2]));
            chk("vreg", 16'(vl), 16'(k[1]));
            chk("ref", 16'(refo), 16'(k[0]));
            rdchk(5'h15, 8'(k));
        end
        $display("test divider and reference done");
        host.wr_reg(5'h16, 8'h00);
        chk("relock", 16'(relock), 16'h0);
        host.wr_reg(5'h16, 8'h01);
        chk("relock", 16'(relock), 16'h1);
        step();
        chk("relock", 16'(relock), 16'h0);
        rdchk(5'h16, 8'h00);
        $display("test relock done");
        @(posedge clk);
        scode <= 4'h0;
        sref <= 1'b1;
        host.wr_reg(5'h1b, 8'h00);
        repeat (8) step();
        chk("strap ratio", 16'(ratio), 16'h1);
        chk("strap ref", 16'(refo), 16'h1);
        $display("test strap done");
        finish_test();
    end
endmodule
`default_nettype wire
